// file: plrc_pkg.sv
// Purpose: Constants for the link status and root-port control register group
// Assumes: 32-bit word registers at byte offsets on a plain strobe port
// Notes:   All registers reset to zero
package plrc_pkg;
    // Register byte offsets
    localparam logic [11:0] OFS_PHY_LINK  = 12'h144;
    localparam logic [11:0] OFS_ROOT_PORT = 12'h148;
    localparam logic [11:0] OFS_MSI_UPPER = 12'h14c;
    localparam logic [11:0] OFS_MSI_LOWER = 12'h150;
    // Link status field positions
    localparam int POS_RATE      = 0;
    localparam int POS_WIDTH     = 1;
    localparam int POS_LTSSM     = 3;
    localparam int POS_REVERSAL  = 9;
    localparam int POS_LINK_UP   = 11;
    localparam int POS_TGT_WIDTH = 16;
    localparam int POS_TGT_RATE  = 18;
    localparam int POS_AUTONOM   = 19;
    localparam int POS_CHANGE    = 20;
    // Root-port field positions
    localparam int POS_BRIDGE_EN = 0;
    localparam int POS_ERR_NE    = 16;
    localparam int POS_ERR_OVF   = 17;
    localparam int POS_INT_NE    = 18;
    localparam int POS_INT_OVF   = 19;
    // Window base field
    localparam int POS_MSI_BASE  = 12;
    localparam int MSI_BASE_W    = 20;
    // Reset value of every register
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    // Link change request codes
    typedef enum logic [1:0] {
        CHG_NONE, CHG_WIDTH, CHG_SPEED, CHG_BOTH
    } plrc_change_type;
endpackage

// file: plrc_regs.sv
// Purpose: Link status, directed link change, root-port bridge control, MSI window
// Assumes: All inputs synchronous to clk_sys; queue status comes from outside
// Notes:   Read data appears the cycle after the read strobe only
//
// Overview of operation
// [RQ1] Bit 0 reads present link rate: 0 lower, 1 higher.
// [RQ2] Bits 2:1 read negotiated lane count: x1, x2, x4, x8.
// [RQ3] Bits 8:3 read training state as given by the link block.
// [RQ4] Bits 10:9 read lane reversal mode: none, 1:0, 3:0, 7:0.
// [RQ5] Bit 11 reads one only while link is in L0 and up.
// [RQ6] Writable target lane count at 17:16, used only for width changes.
// [RQ7] Writable target rate at bit 18, used only for speed changes.
// [RQ8] Writable bit 19 marks a change reliability-driven or autonomous.
// [RQ9] Bits 21:20 start a change: none, width, speed, both.
// [RQ10] Root-port register reads zero and ignores writes unless root port.
// [RQ11] Bridge enable bit 0 gates window forwarding; resets to zero.
// [RQ12] Hardware clears bridge enable when the link goes from up to down.
// [RQ13] Software sets bridge enable after enumeration, before window accesses.
// [RQ14] Bit 16 reads one while the error queue is not empty.
// [RQ15] Bit 17 sets on error message drop; cleared by writing one.
// [RQ16] Bit 18 reads one while the interrupt queue is not empty.
// [RQ17] Bit 19 sets on interrupt message drop; cleared by writing one.
// [RQ18] Upper MSI word writable; reads zero with 32-bit addressing.
// [RQ19] Writes into the 4 KB window at base 31:12 are interrupt messages.
// [RQ20] Only a single message vector is decoded.
// [RQ21] Both window base registers read zero in endpoint configuration.
// [RQ22] Reserved bits read zero and ignore writes.
//
// Our own choice: the address-and-strobe port.
module plrc_regs
    import plrc_pkg::*;
#(
    parameter bit ROOT_PORT = 1'b1,
    parameter bit MSI_64BIT = 1'b1
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        srst,
    // Register port
    input  wire logic [11:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Link block status
    input  wire logic        link_rate,
    input  wire logic [1:0]  link_width,
    input  wire logic [5:0]  ltssm_state,
    input  wire logic [1:0]  lane_reversal,
    input  wire logic        link_up,
    // Directed link change request to the link block
    output logic [1:0]       change_target_width,
    output logic             change_target_rate,
    output logic             change_autonomous,
    output logic [1:0]       change_request,
    // Queue status from the message queues
    input  wire logic        err_queue_not_empty,
    input  wire logic        err_queue_drop,
    input  wire logic        int_queue_not_empty,
    input  wire logic        int_queue_drop,
    // Bridge forwarding and message window decode
    output logic             bridge_enable,
    input  wire logic        rx_memwr_valid,
    input  wire logic [63:0] rx_memwr_addr,
    output logic             rx_msi_hit
);

    typedef struct packed {
        logic [31:0] rdata;
        logic        link_up_q;
        logic [1:0]  tgt_width;
        logic        tgt_rate;
        logic        autonom;
        logic [1:0]  change;
        logic        bridge_en;
        logic        err_ovf;
        logic        int_ovf;
        logic [31:0] msi_upper;
        logic [MSI_BASE_W-1:0] msi_base;
        logic        msi_hit;
    } plrc_state_type;

    plrc_state_type state;
    plrc_state_type next_state;

    logic [31:0] phy_word;
    logic [31:0] rp_word;
    logic        wr_phy;
    logic        wr_rp;
    logic        upper_match;

    // Status fields compose the link word; reserved positions stay zero
    always_comb begin
        phy_word = 32'h0000_0000; // [RQ22]
        phy_word[POS_RATE] = link_rate; // [RQ1]
        phy_word[POS_WIDTH+:2] = link_width; // [RQ2]
        phy_word[POS_LTSSM+:6] = ltssm_state; // [RQ3]
        phy_word[POS_REVERSAL+:2] = lane_reversal; // [RQ4]
        phy_word[POS_LINK_UP] = link_up; // [RQ5]
        phy_word[POS_TGT_WIDTH+:2] = state.tgt_width;
        phy_word[POS_TGT_RATE] = state.tgt_rate;
        phy_word[POS_AUTONOM] = state.autonom;
        phy_word[POS_CHANGE+:2] = state.change;
        rp_word = 32'h0000_0000;
        if (ROOT_PORT) begin // [RQ10]
            rp_word[POS_BRIDGE_EN] = state.bridge_en;
            rp_word[POS_ERR_NE] = err_queue_not_empty; // [RQ14]
            rp_word[POS_ERR_OVF] = state.err_ovf;
            rp_word[POS_INT_NE] = int_queue_not_empty; // [RQ16]
            rp_word[POS_INT_OVF] = state.int_ovf;
        end
    end

    assign wr_phy = reg_wr && (reg_addr == OFS_PHY_LINK);
    assign wr_rp  = reg_wr && (reg_addr == OFS_ROOT_PORT) && ROOT_PORT; // [RQ10]
    // With 32-bit addressing the upper address bits must be zero to match
    assign upper_match = MSI_64BIT ? (rx_memwr_addr[63:32] == state.msi_upper)
                                   : (rx_memwr_addr[63:32] == 32'h0000_0000);

    always_comb begin
        next_state = state;
        next_state.link_up_q = link_up;
        next_state.rdata = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                OFS_PHY_LINK:  next_state.rdata = phy_word;
                OFS_ROOT_PORT: next_state.rdata = rp_word;
                OFS_MSI_UPPER: begin
                    if (ROOT_PORT && MSI_64BIT) begin // [RQ18] [RQ21]
                        next_state.rdata = state.msi_upper;
                    end
                end
                OFS_MSI_LOWER: begin
                    if (ROOT_PORT) begin // [RQ21]
                        next_state.rdata = {state.msi_base, 12'h000}; // [RQ19]
                    end
                end
                default: next_state.rdata = 32'h0000_0000;
            endcase
        end
        if (wr_phy) begin
            next_state.tgt_width = reg_wdata[POS_TGT_WIDTH+:2]; // [RQ6]
            next_state.tgt_rate  = reg_wdata[POS_TGT_RATE]; // [RQ7]
            next_state.autonom   = reg_wdata[POS_AUTONOM]; // [RQ8]
            next_state.change    = reg_wdata[POS_CHANGE+:2]; // [RQ9]
        end
        if (wr_rp) begin
            next_state.bridge_en = reg_wdata[POS_BRIDGE_EN]; // [RQ11] [RQ13]
            if (reg_wdata[POS_ERR_OVF]) begin
                next_state.err_ovf = 1'b0;
            end
            if (reg_wdata[POS_INT_OVF]) begin
                next_state.int_ovf = 1'b0;
            end
        end
        // Link loss wins over a software enable in the same cycle
        if (state.link_up_q && !link_up) begin
            next_state.bridge_en = 1'b0; // [RQ12]
        end
        // Set after clear so a drop during the clearing write is kept
        if (ROOT_PORT && err_queue_drop) begin
            next_state.err_ovf = 1'b1; // [RQ15]
        end
        if (ROOT_PORT && int_queue_drop) begin
            next_state.int_ovf = 1'b1; // [RQ17]
        end
        if (reg_wr && ROOT_PORT && MSI_64BIT && reg_addr == OFS_MSI_UPPER) begin
            next_state.msi_upper = reg_wdata; // [RQ18]
        end
        if (reg_wr && ROOT_PORT && reg_addr == OFS_MSI_LOWER) begin
            next_state.msi_base = reg_wdata[31:POS_MSI_BASE]; // [RQ19]
        end
        // One window, one vector: no table or multi-address decode
        next_state.msi_hit = ROOT_PORT && rx_memwr_valid && upper_match
            && (rx_memwr_addr[31:POS_MSI_BASE] == state.msi_base); // [RQ19] [RQ20]
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign reg_rdata           = state.rdata;
    assign change_target_width = state.tgt_width;
    assign change_target_rate  = state.tgt_rate;
    assign change_autonomous   = state.autonom;
    assign change_request      = state.change;
    assign bridge_enable       = state.bridge_en;
    assign rx_msi_hit          = state.msi_hit;

    chk_bridge_link_drop: assert property (@(posedge clk_sys) disable iff (srst) // [RQ12]
        (link_up && !srst) ##1 !link_up |=> !bridge_enable)
        else $error("Bridge enable survived link down");

    chk_err_ovf_set: assert property (@(posedge clk_sys) disable iff (srst) // [RQ15]
        (err_queue_drop && ROOT_PORT) |=> state.err_ovf)
        else $error("Error overflow not set on drop");

    chk_int_ovf_set: assert property (@(posedge clk_sys) disable iff (srst) // [RQ17]
        (int_queue_drop && ROOT_PORT) |=> state.int_ovf)
        else $error("Interrupt overflow not set on drop");

    chk_err_ovf_hold: assert property (@(posedge clk_sys) disable iff (srst) // [RQ15]
        (state.err_ovf && !(wr_rp && reg_wdata[POS_ERR_OVF])) |=> state.err_ovf)
        else $error("Error overflow cleared without write");

    sequence s_rp_read;
        reg_rd && reg_addr == OFS_ROOT_PORT;
    endsequence

    chk_rp_read_status: assert property (@(posedge clk_sys) disable iff (srst) // [RQ14]
        s_rp_read ##0 ($stable(err_queue_not_empty) [*1]) |=>
            reg_rdata[POS_ERR_NE] == (ROOT_PORT && $past(err_queue_not_empty)))
        else $error("Error queue flag read wrong");

    chk_phy_link_read: assert property (@(posedge clk_sys) disable iff (srst) // [RQ5]
        (reg_rd && reg_addr == OFS_PHY_LINK) |=>
            reg_rdata[POS_LINK_UP] == $past(link_up)
            && reg_rdata[15:12] == 4'h0)
        else $error("Link up bit read wrong");

    chk_change_write: assert property (@(posedge clk_sys) disable iff (srst) // [RQ9]
        wr_phy |=> change_request == $past(reg_wdata[21:20])
            && change_target_width == $past(reg_wdata[17:16]))
        else $error("Link change request not stored");

    chk_read_one_cycle: assert property (@(posedge clk_sys) disable iff (srst) // [RQ22]
        !reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("Read data outside its cycle");

    chk_msi_lower_read: assert property (@(posedge clk_sys) disable iff (srst) // [RQ19]
        (reg_rd && reg_addr == OFS_MSI_LOWER) |=> reg_rdata[11:0] == 12'h000)
        else $error("Window base low bits not zero");

    sequence s_phy_read;
        reg_rd && reg_addr == OFS_PHY_LINK;
    endsequence

    sequence s_upper_read;
        reg_rd && reg_addr == OFS_MSI_UPPER;
    endsequence

    sequence s_lower_read;
        reg_rd && reg_addr == OFS_MSI_LOWER;
    endsequence

    // Clear only counts when no drop lands in the same cycle
    sequence s_err_clear;
        wr_rp && reg_wdata[POS_ERR_OVF] && !err_queue_drop;
    endsequence

    sequence s_int_clear;
        wr_rp && reg_wdata[POS_INT_OVF] && !int_queue_drop;
    endsequence

    sequence s_msi_in_window;
        rx_memwr_valid && rx_memwr_addr[31:POS_MSI_BASE] == state.msi_base;
    endsequence

    chk_rate_read: assert property (@(posedge clk_sys) disable iff (srst) // [RQ1]
        s_phy_read |=> reg_rdata[POS_RATE] == $past(link_rate))
        else $error("Link rate read wrong");

    chk_width_read: assert property (@(posedge clk_sys) disable iff (srst) // [RQ2]
        s_phy_read |=> reg_rdata[2:1] == $past(link_width))
        else $error("Link width read wrong");

    chk_ltssm_read: assert property (@(posedge clk_sys) disable iff (srst) // [RQ3]
        s_phy_read |=> reg_rdata[8:3] == $past(ltssm_state))
        else $error("Training state read wrong");

    chk_reversal_read: assert property (@(posedge clk_sys) disable iff (srst) // [RQ4]
        s_phy_read |=> reg_rdata[10:9] == $past(lane_reversal))
        else $error("Lane reversal read wrong");

    chk_phy_reserved: assert property (@(posedge clk_sys) disable iff (srst) // [RQ22]
        s_phy_read |=> reg_rdata[31:22] == 10'h000)
        else $error("Link word reserved bits not zero");

    chk_target_rate: assert property (@(posedge clk_sys) disable iff (srst) // [RQ7]
        wr_phy |=> change_target_rate == $past(reg_wdata[18]))
        else $error("Target rate not stored");

    chk_autonom_write: assert property (@(posedge clk_sys) disable iff (srst) // [RQ8]
        wr_phy |=> change_autonomous == $past(reg_wdata[19]))
        else $error("Autonomous bit not stored");

    chk_change_hold: assert property (@(posedge clk_sys) disable iff (srst) // [RQ9]
        !wr_phy |=> $stable(change_request) && $stable(change_target_width))
        else $error("Link change request moved without write");

    chk_rp_endpoint_zero: assert property (@(posedge clk_sys) disable iff (srst) // [RQ10]
        s_rp_read ##0 !ROOT_PORT |=> reg_rdata == 32'h0000_0000)
        else $error("Root-port word not zero in endpoint");

    chk_bridge_write: assert property (@(posedge clk_sys) disable iff (srst) // [RQ11]
        wr_rp && !(state.link_up_q && !link_up) |=>
            bridge_enable == $past(reg_wdata[POS_BRIDGE_EN]))
        else $error("Bridge enable not stored");

    chk_bridge_hold: assert property (@(posedge clk_sys) disable iff (srst) // [RQ11]
        !wr_rp |=> !bridge_enable || $past(bridge_enable))
        else $error("Bridge enable rose without write");

    chk_err_ovf_clear: assert property (@(posedge clk_sys) disable iff (srst) // [RQ15]
        s_err_clear |=> !state.err_ovf)
        else $error("Error overflow not cleared");

    chk_int_ovf_clear: assert property (@(posedge clk_sys) disable iff (srst) // [RQ17]
        s_int_clear |=> !state.int_ovf)
        else $error("Interrupt overflow not cleared");

    chk_int_ovf_hold: assert property (@(posedge clk_sys) disable iff (srst) // [RQ17]
        (state.int_ovf && !(wr_rp && reg_wdata[POS_INT_OVF])) |=> state.int_ovf)
        else $error("Interrupt overflow cleared without write");

    chk_int_queue_read: assert property (@(posedge clk_sys) disable iff (srst) // [RQ16]
        s_rp_read |=> reg_rdata[POS_INT_NE] == (ROOT_PORT && $past(int_queue_not_empty)))
        else $error("Interrupt queue flag read wrong");

    chk_rp_reserved: assert property (@(posedge clk_sys) disable iff (srst) // [RQ22]
        s_rp_read |=> reg_rdata[15:1] == 15'h0000 && reg_rdata[31:20] == 12'h000)
        else $error("Root-port reserved bits not zero");

    chk_upper_read: assert property (@(posedge clk_sys) disable iff (srst) // [RQ18]
        s_upper_read |=>
            reg_rdata == ((ROOT_PORT && MSI_64BIT) ? $past(state.msi_upper) : 32'h0000_0000))
        else $error("Upper window word read wrong");

    chk_lower_ep_zero: assert property (@(posedge clk_sys) disable iff (srst) // [RQ21]
        s_lower_read ##0 !ROOT_PORT |=> reg_rdata == 32'h0000_0000)
        else $error("Window base not zero in endpoint");

    chk_msi_hit_window: assert property (@(posedge clk_sys) disable iff (srst) // [RQ19]
        s_msi_in_window ##0 (ROOT_PORT && (MSI_64BIT
            ? rx_memwr_addr[63:32] == state.msi_upper
            : rx_memwr_addr[63:32] == 32'h0000_0000)) |=> rx_msi_hit)
        else $error("Message write in window not decoded");

    chk_msi_hit_miss: assert property (@(posedge clk_sys) disable iff (srst) // [RQ19]
        (rx_memwr_valid && rx_memwr_addr[31:POS_MSI_BASE] != state.msi_base) |=> !rx_msi_hit)
        else $error("Message decoded outside window");

    chk_msi_hit_quiet: assert property (@(posedge clk_sys) disable iff (srst) // [RQ20]
        !rx_memwr_valid |=> !rx_msi_hit)
        else $error("Message hit without a write");

    chk_unmapped_read: assert property (@(posedge clk_sys) disable iff (srst) // [RQ22]
        (reg_rd && reg_addr != OFS_PHY_LINK && reg_addr != OFS_ROOT_PORT
            && reg_addr != OFS_MSI_UPPER && reg_addr != OFS_MSI_LOWER)
            |=> reg_rdata == 32'h0000_0000)
        else $error("Unmapped read not zero");

    // No disable here: reset itself is what is watched
    chk_reset_clears: assert property (@(posedge clk_sys) // [RQ11]
        srst |=> reg_rdata == 32'h0000_0000 && !bridge_enable && change_request == 2'h0)
        else $error("Reset left state behind");
endmodule

// file: plrc_regs_tb_top.sv
// Purpose: Self-checking bench for the link status and root-port register group
// Assumes: Read data stands only in the cycle after the read strobe
// Notes:   Second instance is endpoint with 32-bit messages, for the zero reads
`define CHK(name, exp, got) begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
        bad_count++; \
        $display("MISMATCH %s expected %h seen %h", name, exp, got); \
    end \
end
module plrc_regs_tb_top
    import plrc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_sys = 1'b0;
    logic        srst = 1'b1;
    logic [11:0] reg_addr = 12'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata, ep_rdata, rd_main, rd_ep, w, exp_status;
    logic        link_rate = 1'b0;
    logic [1:0]  link_width = 2'h0;
    logic [5:0]  ltssm_state = 6'h0;
    logic [1:0]  lane_reversal = 2'h0;
    logic        link_up = 1'b0;
    logic [1:0]  change_target_width, change_request;
    logic        change_target_rate, change_autonomous, bridge_enable, ep_bridge, rx_msi_hit;
    logic        err_queue_not_empty = 1'b0;
    logic        err_queue_drop = 1'b0;
    logic        int_queue_not_empty = 1'b0;
    logic        int_queue_drop = 1'b0;
    logic        rx_memwr_valid = 1'b0;
    logic [63:0] rx_memwr_addr = 64'h0;
    int          bad_count = 0;
    int          total_checks = 0;

    always #20 clk_sys = ~clk_sys;

    plrc_regs plrc_regs_i (
        .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_rate(link_rate),
        .link_width(link_width), .ltssm_state(ltssm_state), .lane_reversal(lane_reversal),
        .link_up(link_up), .change_target_width(change_target_width),
        .change_target_rate(change_target_rate), .change_autonomous(change_autonomous),
        .change_request(change_request), .err_queue_not_empty(err_queue_not_empty),
        .err_queue_drop(err_queue_drop), .int_queue_not_empty(int_queue_not_empty),
        .int_queue_drop(int_queue_drop), .bridge_enable(bridge_enable),
        .rx_memwr_valid(rx_memwr_valid), .rx_memwr_addr(rx_memwr_addr), .rx_msi_hit(rx_msi_hit)
    );
    // Endpoint build: only its read data and bridge enable are watched
    plrc_regs #(.ROOT_PORT(1'b0), .MSI_64BIT(1'b0)) plrc_regs_ep_i (
        .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(ep_rdata), .link_rate(link_rate),
        .link_width(link_width), .ltssm_state(ltssm_state), .lane_reversal(lane_reversal),
        .link_up(link_up), .change_target_width(), .change_target_rate(),
        .change_autonomous(), .change_request(), .err_queue_not_empty(err_queue_not_empty),
        .err_queue_drop(err_queue_drop), .int_queue_not_empty(int_queue_not_empty),
        .int_queue_drop(int_queue_drop), .bridge_enable(ep_bridge),
        .rx_memwr_valid(rx_memwr_valid), .rx_memwr_addr(rx_memwr_addr), .rx_msi_hit()
    );

    task automatic end_sim();
        if (bad_count == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask

    // Read data is only valid the cycle after the strobe, so sample it there
    task automatic check_reg(input string name, input logic [11:0] a,
                             input logic [31:0] exp_main, input logic [31:0] exp_ep);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        rd_main = reg_rdata;
        rd_ep = ep_rdata;
        `CHK(name, exp_main, rd_main)
        `CHK({name, " ep"}, exp_ep, rd_ep)
    endtask

    task automatic msi_write(input logic [63:0] a, input logic exp_hit);
        @(posedge clk_sys);
        rx_memwr_valid <= 1'b1;
        rx_memwr_addr <= a;
        @(posedge clk_sys);
        rx_memwr_valid <= 1'b0;
        #1;
        `CHK("msi hit", exp_hit, rx_msi_hit)
    endtask

    initial begin
        repeat (16) @(posedge clk_sys);
        srst <= 1'b0;
        check_reg("phy rst", OFS_PHY_LINK, RESET_WORD, RESET_WORD);
        check_reg("rp rst", OFS_ROOT_PORT, RESET_WORD, RESET_WORD);
        check_reg("up rst", OFS_MSI_UPPER, RESET_WORD, RESET_WORD);
        check_reg("lo rst", OFS_MSI_LOWER, RESET_WORD, RESET_WORD);
        reg_write(12'h154, 32'hffff_ffff);
        check_reg("unmapped", 12'h154, 32'h0, 32'h0);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            link_rate <= i[0];
            link_width <= i[1:0];
            lane_reversal <= 2'(3 - i);
            ltssm_state <= 6'(i * 21);
            link_up <= i[0];
            exp_status = {20'h0, i[0], 2'(3 - i), 6'(i * 21), i[1:0], i[0]};
            check_reg("status", OFS_PHY_LINK, exp_status, exp_status);
        end
        for (int c = 0; c < 4; c++) begin
            w = {10'h3ff, c[1:0], c[0], c[1], ~c[1:0], 16'hffff};
            reg_write(OFS_PHY_LINK, w);
            `CHK("chg req", c[1:0], change_request)
            `CHK("chg width", ~c[1:0], change_target_width)
            `CHK("chg rate", c[1], change_target_rate)
            `CHK("chg auton", c[0], change_autonomous)
            w = {10'h0, w[21:16], exp_status[15:0]};
            check_reg("phy rw", OFS_PHY_LINK, w, w);
        end
        // Link is up here, as software would see after enumeration
        reg_write(OFS_ROOT_PORT, 32'hffff_ffff);
        `CHK("bridge", 1'b1, bridge_enable)
        `CHK("ep bridge", 1'b0, ep_bridge)
        @(posedge clk_sys);
        err_queue_not_empty <= 1'b1;
        err_queue_drop <= 1'b1;
        @(posedge clk_sys);
        err_queue_drop <= 1'b0;
        check_reg("err set", OFS_ROOT_PORT, 32'h0003_0001, 32'h0);
        reg_write(OFS_ROOT_PORT, 32'h0002_0001);
        check_reg("err clr", OFS_ROOT_PORT, 32'h0001_0001, 32'h0);
        @(posedge clk_sys);
        err_queue_not_empty <= 1'b0;
        int_queue_not_empty <= 1'b1;
        int_queue_drop <= 1'b1;
        @(posedge clk_sys);
        int_queue_drop <= 1'b0;
        check_reg("int set", OFS_ROOT_PORT, 32'h000c_0001, 32'h0);
        reg_write(OFS_ROOT_PORT, 32'h0008_0001);
        check_reg("int clr", OFS_ROOT_PORT, 32'h0004_0001, 32'h0);
        @(posedge clk_sys);
        link_up <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        `CHK("link drop", 1'b0, bridge_enable)
        check_reg("rp down", OFS_ROOT_PORT, 32'h0004_0000, 32'h0);
        reg_write(OFS_MSI_UPPER, 32'h1234_5678);
        reg_write(OFS_MSI_LOWER, 32'hcafe_bfff);
        check_reg("msi up", OFS_MSI_UPPER, 32'h1234_5678, 32'h0);
        check_reg("msi lo", OFS_MSI_LOWER, 32'hcafe_b000, 32'h0);
        msi_write(64'h1234_5678_cafe_b000, 1'b1);
        msi_write(64'h1234_5678_cafe_bffc, 1'b1);
        msi_write(64'h1234_5678_cafe_c000, 1'b0);
        msi_write(64'h1234_5679_cafe_b004, 1'b0);
        end_sim();
    end

    // Tests need under a hundred cycles; a hang runs far past that
    initial begin
        repeat (2000) @(posedge clk_sys);
        bad_count++;
        end_sim();
    end
endmodule
